/* File: e1_reset_cfg_pkg.sv */
// Constants and reset value function for the E1 reset default configuration bank
package e1_reset_cfg_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam int unsigned NUM_REGS = 64;
  localparam logic [5:0] IDX_FRAME_MODE_A = 6'h00;
  localparam logic [5:0] IDX_FRAME_MODE_B = 6'h01;
  localparam logic [5:0] IDX_FRAME_MODE_C = 6'h02;
  localparam logic [5:0] IDX_SYSTEM_IF_CFG_A = 6'h03;
  localparam logic [5:0] IDX_LOOP_CTRL = 6'h06;
  localparam logic [5:0] IDX_TX_SERVICE_WORD = 6'h07;
  localparam logic [5:0] IDX_TX_SPARE_BITS = 6'h08;
  localparam logic [5:0] IDX_TSW_MASK = 6'h09;
  localparam logic [5:0] IDX_TX_OFFSET_A = 6'h0a;
  localparam logic [5:0] IDX_TX_OFFSET_B = 6'h0b;
  localparam logic [5:0] IDX_RX_OFFSET_A = 6'h0c;
  localparam logic [5:0] IDX_RX_OFFSET_B = 6'h0d;
  localparam logic [5:0] IDX_IDLE_CODE = 6'h0e;
  localparam logic [5:0] IDX_IDLE_CHANNEL_SELECT = 6'h0f;
  localparam logic [5:0] IDX_LINE_IF_MODE_A = 6'h13;
  localparam logic [5:0] IDX_LINE_IF_MODE_B = 6'h14;
  localparam logic [5:0] IDX_LOS_DETECT_COUNT = 6'h15;
  localparam logic [5:0] IDX_LOS_RECOVER_COUNT = 6'h16;
  localparam logic [5:0] IDX_TX_PULSE_MASK = 6'h17;
  localparam logic [5:0] IDX_IRQ_MASK_REGS = 6'h1a;
  localparam logic [5:0] IDX_RX_SLOT_SELECT = 6'h20;
  localparam logic [5:0] IDX_TX_SLOT_SELECT = 6'h24;
  localparam logic [5:0] IDX_SLOT_STROBE_SELECT_B = 6'h28;
  localparam logic [5:0] IDX_SLOT_STROBE_SELECT_C = 6'h29;
  localparam logic [5:0] IDX_GLOBAL_CONFIG = 6'h2a;
  localparam logic [5:0] IDX_CLOCK_MODE_A = 6'h2b;
  localparam logic [5:0] IDX_CLOCK_MODE_B = 6'h2c;
  localparam logic [5:0] IDX_GLOBAL_CLOCK_MODE = 6'h2d;
  localparam logic [5:0] IDX_LAST_CFG = 6'h32;
  localparam logic [5:0] IDX_STATUS = 6'h3f;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned LINE_STANDARD_SELECT_BIT = 0;
  localparam int unsigned TX_TRISTATE_BIT = 6;
  localparam int unsigned ST_E1_MODE_BIT = 0;
  localparam int unsigned ST_LINE_DRIVE_BIT = 1;
  localparam int unsigned ST_CLEAR_BUSY_BIT = 2;
  localparam int unsigned ST_TRISTATE_BIT = 3;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_OFFSET_B = 8'h9c;
  localparam logic [7:0] RST_TX_PULSE_MASK_0 = 8'h40;
  localparam logic [7:0] RST_TX_PULSE_MASK_1 = 8'h03;
  localparam logic [7:0] RST_TX_PULSE_MASK_2 = 8'h7b;
  localparam logic [7:0] RST_IRQ_MASK = 8'hff;

  // ****************************************************************
  // Timing: minimum chip clear hold, in ns and in 25 ns cycles
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_PS = 25000;
  localparam int unsigned CHIP_CLEAR_MIN_NS = 10000;
  localparam int unsigned CHIP_CLEAR_CYCLES =
    (CHIP_CLEAR_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ****************************************************************
  // AXI4-Lite responses
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Reset value of one configuration register, by index
  function automatic logic [7:0] reset_value(input logic [5:0] idx);
    if (idx == IDX_TX_OFFSET_B || idx == IDX_RX_OFFSET_B) begin
      return RST_OFFSET_B;
    end
    if (idx == IDX_TX_PULSE_MASK) begin
      return RST_TX_PULSE_MASK_0;
    end
    if (idx == IDX_TX_PULSE_MASK + 6'h01) begin
      return RST_TX_PULSE_MASK_1;
    end
    if (idx == IDX_TX_PULSE_MASK + 6'h02) begin
      return RST_TX_PULSE_MASK_2;
    end
    if (idx >= IDX_IRQ_MASK_REGS && idx < IDX_RX_SLOT_SELECT) begin
      return RST_IRQ_MASK;
    end
    return RST_ZERO;
  endfunction

endpackage

/* File: e1_reset_default_config.sv */
// AXI4-Lite register bank holding the E1 reset default configuration
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module e1_reset_default_config #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic chip_clear_input_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic e1_mode,
  output logic line_tx_oe,
  output logic clear_busy
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [1:0] {K_CFG, K_STATUS, K_NONE} reg_kind_t;

  typedef struct packed {
    logic [e1_reset_cfg_pkg::NUM_REGS-1:0][7:0] regs;
    logic [15:0] clr_cnt;
    logic busy;
    logic aw_ok;
    logic w_ok;
    logic [5:0] widx;
    reg_kind_t wkind;
    logic [7:0] wdat;
    logic wlane;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic e1_mode;
    logic line_oe;
  } state_t;

  state_t q, d;
  logic [7:0] status_byte;

  // Classifies a byte address; shared by the read and write paths
  function automatic reg_kind_t kind_of(input logic [ADDR_W-1:0] a);
    logic [5:0] i;
    i = a[7:2];
    if (a[1:0] != 2'h0) begin
      return K_NONE;
    end
    if (i == e1_reset_cfg_pkg::IDX_STATUS) begin
      return K_STATUS;
    end
    if (i <= e1_reset_cfg_pkg::IDX_LAST_CFG) begin
      return K_CFG;
    end
    return K_NONE;
  endfunction

  // Live status, rebuilt every cycle rather than on request
  always_comb begin
    status_byte = 8'h00;
    status_byte[e1_reset_cfg_pkg::ST_E1_MODE_BIT] = q.e1_mode;
    status_byte[e1_reset_cfg_pkg::ST_LINE_DRIVE_BIT] = q.line_oe;
    status_byte[e1_reset_cfg_pkg::ST_CLEAR_BUSY_BIT] = q.busy;
    status_byte[e1_reset_cfg_pkg::ST_TRISTATE_BIT] =
      q.regs[e1_reset_cfg_pkg::IDX_TX_PULSE_MASK + 6'h02]
        [e1_reset_cfg_pkg::TX_TRISTATE_BIT];
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    d = q;

    // Chip clear filter: shorter low pulses are ignored
    if (chip_clear_input_n) begin
      d.clr_cnt = 16'h0000;
      d.busy = 1'b0;
    end else if (q.clr_cnt ==
                 16'(e1_reset_cfg_pkg::CHIP_CLEAR_CYCLES - 1)) begin
      d.busy = 1'b1;
    end else begin
      d.clr_cnt = q.clr_cnt + 16'h0001;
    end

    // Write address and data are taken in either order
    if (s_axi_awvalid && q.awready) begin
      d.aw_ok = 1'b1;
      d.widx = s_axi_awaddr[7:2];
      d.wkind = kind_of(s_axi_awaddr);
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_ok = 1'b1;
      d.wdat = s_axi_wdata[7:0];
      d.wlane = s_axi_wstrb[0]; // byte or word write both land
    end

    // Commit once both halves are in and no response is pending
    if (q.aw_ok && q.w_ok && !q.bvalid) begin
      d.aw_ok = 1'b0;
      d.w_ok = 1'b0;
      d.bvalid = 1'b1;
      unique case (q.wkind)
        K_CFG: begin
          // Writes during the clear state would be lost; refuse them
          if (q.busy) begin
            d.bresp = e1_reset_cfg_pkg::RESP_SLVERR;
          end else begin
            d.bresp = e1_reset_cfg_pkg::RESP_OKAY;
            if (q.wlane) begin
              d.regs[q.widx] = q.wdat;
            end
          end
        end
        K_STATUS: d.bresp = e1_reset_cfg_pkg::RESP_SLVERR;
        default: d.bresp = e1_reset_cfg_pkg::RESP_DECERR;
      endcase
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    // Read path: one cycle from address taken to data valid
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rdata = 32'h0000_0000;
      unique case (kind_of(s_axi_araddr))
        K_CFG: begin
          d.rdata[7:0] = q.regs[s_axi_araddr[7:2]];
          d.rresp = e1_reset_cfg_pkg::RESP_OKAY;
        end
        K_STATUS: begin
          d.rdata[7:0] = status_byte;
          d.rresp = e1_reset_cfg_pkg::RESP_OKAY;
        end
        default: d.rresp = e1_reset_cfg_pkg::RESP_DECERR;
      endcase
    end

    // Clear state reloads every default each cycle
    if (d.busy) begin
      for (int i = 0; i < e1_reset_cfg_pkg::NUM_REGS; i++) begin
        d.regs[i] = e1_reset_cfg_pkg::reset_value(6'(i));
      end
    end

    // Readies follow the pending state so nothing is taken twice
    d.awready = !d.aw_ok && !d.bvalid;
    d.wready = !d.w_ok && !d.bvalid;
    d.arready = !d.rvalid;

    // Line standard bit low means E1
    d.e1_mode = !d.regs[e1_reset_cfg_pkg::IDX_FRAME_MODE_B]
                 [e1_reset_cfg_pkg::LINE_STANDARD_SELECT_BIT];
    // Driver off in clear state or while the pulse mask asks tristate
    d.line_oe = !d.busy &&
      !d.regs[e1_reset_cfg_pkg::IDX_TX_PULSE_MASK + 6'h02]
        [e1_reset_cfg_pkg::TX_TRISTATE_BIT];
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Defaults for the whole bank
      // Zero for slots, config and clock modes
      for (int i = 0; i < e1_reset_cfg_pkg::NUM_REGS; i++) begin
        q.regs[i] <= e1_reset_cfg_pkg::reset_value(6'(i));
      end
      q.clr_cnt <= 16'h0000;
      q.busy <= 1'b0;
      q.aw_ok <= 1'b0;
      q.w_ok <= 1'b0;
      q.widx <= 6'h00;
      q.wkind <= K_NONE;
      q.wdat <= 8'h00;
      q.wlane <= 1'b0;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.bvalid <= 1'b0;
      q.bresp <= e1_reset_cfg_pkg::RESP_OKAY;
      q.arready <= 1'b1;
      q.rvalid <= 1'b0;
      q.rdata <= 32'h0000_0000;
      q.rresp <= e1_reset_cfg_pkg::RESP_OKAY;
      q.e1_mode <= 1'b1;
      q.line_oe <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // Every output comes straight from a flip-flop
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign e1_mode = q.e1_mode;
  assign line_tx_oe = q.line_oe;
  assign clear_busy = q.busy;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_clear_held;
    !chip_clear_input_n && q.clr_cnt ==
      16'(e1_reset_cfg_pkg::CHIP_CLEAR_CYCLES - 1);
  endsequence

  sequence s_both_halves;
    q.aw_ok && q.w_ok && !q.bvalid;
  endsequence

  a_clear_enters_reset: assert property (
    s_clear_held |=> clear_busy)
    else $error("chip clear held but no reset state");

  a_short_clear_ignored: assert property (
    chip_clear_input_n |=> !clear_busy && q.clr_cnt == 16'h0000)
    else $error("reset state without full clear hold");

  a_reset_driver_off: assert property (
    clear_busy |-> !line_tx_oe)
    else $error("line driver on during reset state");

  a_reset_loads_defaults: assert property (
    s_clear_held |=> ##1 q.regs[e1_reset_cfg_pkg::IDX_TX_PULSE_MASK]
      == 8'h40 && q.regs[e1_reset_cfg_pkg::IDX_TX_OFFSET_B] == 8'h9c)
    else $error("defaults not loaded in reset state");

  a_irq_masks_set: assert property (
    clear_busy ##1 clear_busy |-> q.regs[e1_reset_cfg_pkg::IDX_IRQ_MASK_REGS]
      == 8'hff)
    else $error("interrupt mask not all ones in reset");

  a_e1_after_clear: assert property (
    clear_busy ##1 clear_busy |-> e1_mode)
    else $error("device not in E1 mode in reset state");

  a_status_readonly: assert property (
    s_both_halves and ##0 (q.wkind == K_STATUS) |=> s_axi_bvalid
      && s_axi_bresp == e1_reset_cfg_pkg::RESP_SLVERR)
    else $error("status write not refused");

  a_write_answer: assert property (
    s_both_halves |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write response missing");

  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
      && s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read data not returned in one cycle");

  a_byte_write_lands: assert property (
    s_both_halves and ##0 (q.wkind == K_CFG && q.wlane && !q.busy
      && !d.busy) |=> q.regs[$past(q.widx)] == $past(q.wdat))
    else $error("byte write did not land");

  sequence s_busy_settled;
    clear_busy ##1 clear_busy;
  endsequence

  a_clear_hold_full: assert property (
    $rose(clear_busy) |-> $past(q.clr_cnt) ==
      16'(e1_reset_cfg_pkg::CHIP_CLEAR_CYCLES - 1))
    else $error("reset state entered before full clear hold");

  a_busy_write_refused: assert property (
    s_both_halves ##0 (q.wkind == K_CFG && q.busy) |=>
      s_axi_bresp == e1_reset_cfg_pkg::RESP_SLVERR)
    else $error("config write accepted in reset state");

  a_unmapped_refused: assert property (
    s_both_halves ##0 (q.wkind == K_NONE) |=>
      s_axi_bresp == e1_reset_cfg_pkg::RESP_DECERR)
    else $error("unmapped write not refused");

  a_status_live: assert property (
    s_axi_arvalid && s_axi_arready && kind_of(s_axi_araddr) == K_STATUS
      |=> s_axi_rdata[e1_reset_cfg_pkg::ST_E1_MODE_BIT] == $past(e1_mode)
      && s_axi_rdata[e1_reset_cfg_pkg::ST_LINE_DRIVE_BIT] ==
        $past(line_tx_oe)
      && s_axi_rdata[e1_reset_cfg_pkg::ST_CLEAR_BUSY_BIT] ==
        $past(clear_busy))
    else $error("status read does not show live state");

  a_frame_mode_clear: assert property (
    s_busy_settled |-> q.regs[e1_reset_cfg_pkg::IDX_FRAME_MODE_A] == 8'h00
      && q.regs[e1_reset_cfg_pkg::IDX_FRAME_MODE_B] == 8'h00
      && q.regs[e1_reset_cfg_pkg::IDX_FRAME_MODE_C] == 8'h00)
    else $error("frame mode register not clear in reset state");

  a_offset_defaults: assert property (
    s_busy_settled |-> q.regs[e1_reset_cfg_pkg::IDX_TX_OFFSET_A] == 8'h00
      && q.regs[e1_reset_cfg_pkg::IDX_TX_OFFSET_B] == 8'h9c
      && q.regs[e1_reset_cfg_pkg::IDX_RX_OFFSET_A] == 8'h00
      && q.regs[e1_reset_cfg_pkg::IDX_RX_OFFSET_B] == 8'h9c)
    else $error("offset register not at default in reset state");

  a_pulse_mask_defaults: assert property (
    s_busy_settled |-> q.regs[e1_reset_cfg_pkg::IDX_TX_PULSE_MASK] == 8'h40
      && q.regs[e1_reset_cfg_pkg::IDX_TX_PULSE_MASK + 6'h01] == 8'h03
      && q.regs[e1_reset_cfg_pkg::IDX_TX_PULSE_MASK + 6'h02] == 8'h7b)
    else $error("pulse mask not at default in reset state");

  a_clock_mode_clear: assert property (
    s_busy_settled |-> q.regs[e1_reset_cfg_pkg::IDX_CLOCK_MODE_A] == 8'h00
      && q.regs[e1_reset_cfg_pkg::IDX_CLOCK_MODE_B] == 8'h00
      && q.regs[e1_reset_cfg_pkg::IDX_GLOBAL_CLOCK_MODE] == 8'h00)
    else $error("clock mode register not clear in reset state");

  // Tristate request in the pulse mask must keep the driver off
  a_tristate_holds: assert property (
    q.regs[e1_reset_cfg_pkg::IDX_TX_PULSE_MASK + 6'h02]
      [e1_reset_cfg_pkg::TX_TRISTATE_BIT] |-> !line_tx_oe)
    else $error("line driver on while pulse mask asks tristate");

endmodule

`default_nettype wire

/* File: e1_host_model.sv */
// Host processor model: register bus master and chip clear driver
`timescale 1ns/1ps
`default_nettype none

module e1_host_model (
  input wire logic aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready,
  output logic clear_n
);
  // ****************************************************************
  // Bus master tasks
  // ****************************************************************
  // Idle bus at time zero, chip clear released
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    clear_n = 1'b1;
  end

  // One write; each channel is released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  // One read; no cycle count is assumed, the bench timeout guards it
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Chip clear; the caller times the low phase, clock keeps running
  task automatic clear_low();
    @(posedge aclk);
    clear_n <= 1'b0;
  endtask

  task automatic clear_high();
    @(posedge aclk);
    clear_n <= 1'b1;
  endtask
endmodule

`default_nettype wire

/* File: tb_top.sv */
// Self-checking testbench for the E1 reset default configuration bank
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic aclk, aresetn, clear_n, awvalid, awready, wvalid, wready;
  logic bvalid, bready, arvalid, arready, rvalid, rready;
  logic e1_mode, line_tx_oe, clear_busy, busy_m;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [7:0] m [64];
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;

  e1_reset_default_config dut_u (.aclk(aclk), .aresetn(aresetn),
    .chip_clear_input_n(clear_n), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .e1_mode(e1_mode),
    .line_tx_oe(line_tx_oe), .clear_busy(clear_busy));

  e1_host_model host_u (.aclk, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .clear_n);

  // ****************************************************************
  // Reference model and compare tasks
  // ****************************************************************
  // Default value of each register index
  function automatic logic [7:0] dflt(int i);
    case (i)
      'h0b, 'h0d: return 8'h9c;
      'h17: return 8'h40;
      'h18: return 8'h03;
      'h19: return 8'h7b;
      default: return (i >= 'h1a && i <= 'h1f) ? 8'hff : 8'h00;
    endcase
  endfunction

  // Live status word: tristate, busy, driver enable, E1 mode
  function automatic logic [31:0] st_exp();
    return {28'h000_0000, m['h19][6], busy_m, ~m['h19][6] & ~busy_m,
            ~m['h01][0]};
  endfunction

  task automatic tally(bit ok, string what);
    n_checks++;
    if (!ok) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask

  task automatic chk_data(logic [31:0] g, logic [31:0] e);
    tally(g === e, "read data");
  endtask

  task automatic chk_resp(logic [1:0] g, logic [1:0] e);
    tally(g === e, "response code");
  endtask

  task automatic chk_pin(logic g, logic e);
    tally(g === e, "output pin level");
  endtask

  // Read one byte address and compare with the model
  task automatic rdc(logic [7:0] a);
    int i = a[7:2];
    bit ok = a[1:0] == 2'h0 && (i <= 'h32 || i == 'h3f);
    logic [31:0] d;
    logic [1:0] r;
    host_u.rd(a, d, r);
    chk_resp(r, ok ? e1_reset_cfg_pkg::RESP_OKAY
                   : e1_reset_cfg_pkg::RESP_DECERR);
    chk_data(d, !ok ? 32'h0 : i == 'h3f ? st_exp() : {24'h0, m[i]});
  endtask

  // Write one byte address; the model follows only accepted writes
  task automatic wrc(logic [7:0] a, logic [31:0] d, logic [3:0] s);
    int i = a[7:2];
    logic [1:0] r;
    logic [1:0] e;
    e = (a[1:0] != 2'h0 || (i > 'h32 && i != 'h3f))
        ? e1_reset_cfg_pkg::RESP_DECERR
        : (i == 'h3f || busy_m) ? e1_reset_cfg_pkg::RESP_SLVERR
        : e1_reset_cfg_pkg::RESP_OKAY;
    host_u.wr(a, d, s, r);
    chk_resp(r, e);
    if (e == e1_reset_cfg_pkg::RESP_OKAY && s[0]) m[i] = d[7:0];
  endtask

  task automatic give_verdict();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ****************************************************************
  // Clock, timeout and test sequence
  // ****************************************************************
  // Clock never stops, also while chip clear is held low
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Whole run needs under two thousand cycles; this only cuts a hang
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      give_verdict();
    end
  end

  initial begin
    logic [7:0] a;
    logic [31:0] d;
    aresetn = 1'b0;
    busy_m = 1'b0;
    void'($urandom(32'h4ecf_957d));
    for (int i = 0; i < 64; i++) m[i] = dflt(i);
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 64; i++) rdc(8'(i * 4));
    rdc(8'h05);
    rdc(8'h18);
    rdc(8'h2c);
    rdc(8'h3c);
    rdc(8'h4c);
    rdc(8'h64);
    rdc(8'h7c);
    rdc(8'ha4);
    rdc(8'ha8);
    rdc(8'hac);
    rdc(8'hb0);
    rdc(8'hc8);
    #1;
    chk_pin(e1_mode, 1'b1);
    chk_pin(line_tx_oe, 1'b0);
    chk_pin(clear_busy, 1'b0);
    $display("test reset_defaults done");
    repeat (60) begin
      a = 8'($urandom_range(0, 'h33) * 4);
      d = $urandom;
      if (a == 8'h04) d[0] = 1'b0;
      wrc(a, d, 4'($urandom));
      rdc(a);
    end
    wrc(8'h00, 32'hffff_ff5a, 4'h1);
    rdc(8'h00);
    wrc(8'hfc, 32'h0000_0000, 4'hf);
    wrc(8'hd0, 32'h0000_00aa, 4'hf);
    rdc(8'hd0);
    $display("test program_access done");
    wrc(8'h04, 32'h0000_0001, 4'hf);
    #1;
    chk_pin(e1_mode, 1'b0);
    rdc(8'hfc);
    wrc(8'h04, 32'h0000_0000, 4'h1);
    wrc(8'h64, 32'h0000_003b, 4'hf);
    #1;
    chk_pin(e1_mode, 1'b1);
    chk_pin(line_tx_oe, 1'b1);
    rdc(8'hfc);
    $display("test live_status done");
    host_u.clear_low();
    repeat (300) @(posedge aclk);
    host_u.clear_high();
    repeat (3) @(posedge aclk);
    #1;
    chk_pin(clear_busy, 1'b0);
    rdc(8'h64);
    host_u.clear_low();
    repeat (405) @(posedge aclk);
    #1;
    busy_m = 1'b1;
    for (int i = 0; i < 64; i++) m[i] = dflt(i);
    chk_pin(clear_busy, 1'b1);
    chk_pin(line_tx_oe, 1'b0);
    wrc(8'h00, 32'h0000_0055, 4'hf);
    rdc(8'hfc);
    host_u.clear_high();
    repeat (3) @(posedge aclk);
    #1;
    busy_m = 1'b0;
    chk_pin(clear_busy, 1'b0);
    for (int i = 0; i < 64; i++) rdc(8'(i * 4));
    $display("test chip_clear done");
    give_verdict();
  end
endmodule

`default_nettype wire
